// ### rtl/sws_top.sv
// Serial control port of the six-channel low side switch with per-channel fault timing
// Contract
// - A shorted output is re-enabled in current limit for a retry window of 25 to 100 us.
// - Between retries the shorted output stays disabled for 3.0 to 6.0 ms, nominally 4.5 ms.
// - An off-state open load is qualified within 100 us; the master waits that long to read.
// - An on-state open load is qualified within 12 ms; the master waits that long to read.
// - Serial out is driven only while chip select is low, enabled and released within 110 ns; the code takes 2 to 3 mclk cycles, up to 120 ns.
// - Each serial out bit changes after a serial clock falling edge, valid within 80 ns; the code takes 2 to 3 mclk cycles, 80 to 120 ns.
// - The master sets each serial in bit before the rising clock edge, where it is sampled.
// - New output states take effect after chip select rises, switching 1.0 to 10 us later.
// - Frames are 8 or 16 bits, MSB first, the low six bits commanding channels five to zero.
// - Reset disables all outputs and clears every fault bit.
// - While mode override is high serial out stays off and serial control is ignored.
`timescale 1ns/1ps
`include "sws_defs.svh"
module sws_top #(
    parameter int CHANNELS    = `SWS_CMD_CH_BITS,
    parameter int RETRY_CYC   = `SWS_RETRY_US * `SWS_CLK_MHZ,
    parameter int REFRESH_CYC = `SWS_REFRESH_NOM_US * `SWS_CLK_MHZ,
    parameter int OFFSENS_CYC = `SWS_OFF_SENSE_US * `SWS_CLK_MHZ,
    parameter int ONSENS_CYC  = `SWS_ON_SENSE_US * `SWS_CLK_MHZ,
    parameter int SWDLY_CYC   = `SWS_SWITCH_DLY_US * `SWS_CLK_MHZ
) (
    input  wire logic                mclk,
    input  wire logic                reset_n,
    input  wire logic                spiCs_n,
    input  wire logic                spiSclk,
    input  wire logic                spiSi,
    output logic                     spiSo,
    output logic                     spiSoOe,
    input  wire logic                modeOverride,
    input  wire logic [CHANNELS-1:0] shortSense,
    input  wire logic [CHANNELS-1:0] openSense,
    output logic      [CHANNELS-1:0] gateOn
);
    logic [2:0]  csSyncReg, sclkSyncReg;
    logic [1:0]  siSyncReg, modeSyncReg;
    logic [15:0] rxReg, rxNext;
    logic [15:0] txReg, txNext;
    logic [4:0]  bitCntReg, bitCntNext;
    logic [CHANNELS-1:0] cmdReg, cmdNext;
    logic [CHANNELS-1:0] pendReg, pendNext;
    logic [7:0]  dlyReg, dlyNext;
    logic        dlyRunReg, dlyRunNext;
    logic        soReg, soNext;
    logic        oeReg, oeNext;
    logic [CHANNELS-1:0] faultQual;
    logic        csLow, csFall, csRise, sclkRise, sclkFall, siBit, modeHi;

    // Two-flop synchronisers; the third stage only feeds the edge detectors
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            csSyncReg   <= 3'h7;
            sclkSyncReg <= 3'h0;
            siSyncReg   <= 2'h0;
            modeSyncReg <= 2'h0;
        end
        else
        begin
            csSyncReg   <= {csSyncReg[1:0], spiCs_n};
            sclkSyncReg <= {sclkSyncReg[1:0], spiSclk};
            siSyncReg   <= {siSyncReg[0], spiSi};
            modeSyncReg <= {modeSyncReg[0], modeOverride};
        end
    end

    // Edge finders on the settled synchroniser stages; stage one is never read here
    function automatic logic syncRise(input logic [2:0] syncVal);
        syncRise = ~syncVal[2] & syncVal[1];
    endfunction

    function automatic logic syncFall(input logic [2:0] syncVal);
        syncFall = syncVal[2] & ~syncVal[1];
    endfunction

    assign csLow    = ~csSyncReg[1];
    assign csFall   = syncFall(csSyncReg);
    assign csRise   = syncRise(csSyncReg);
    assign sclkRise = syncRise(sclkSyncReg);
    assign sclkFall = syncFall(sclkSyncReg);
    assign siBit    = siSyncReg[1];
    assign modeHi   = modeSyncReg[1];

    // Receive side: sample on the rising serial clock, count one bit past a long frame
    always_comb
    begin
        rxNext     = rxReg;
        bitCntNext = bitCntReg;
        if (csFall)
            bitCntNext = '0;
        else if (csLow && sclkRise && bitCntReg != 5'h11)
        begin
            // A seventeenth bit marks the frame too long; the count then stops
            if (bitCntReg != 5'h10)
                rxNext = {rxReg[14:0], siBit};
            bitCntNext = bitCntReg + 5'h01;
        end
    end

    // Receive registers
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rxReg     <= 16'h0000;
            bitCntReg <= 5'h00;
        end
        else
        begin
            rxReg     <= rxNext;
            bitCntReg <= bitCntNext;
        end
    end

    // Transmit side: fault byte loads at select, one bit moves per falling serial clock
    always_comb
    begin
        txNext = txReg;
        soNext = soReg;
        oeNext = csLow & ~modeHi; // Driven only inside the frame
        if (csFall)
        begin
            txNext = {{(16 - CHANNELS){1'b0}}, faultQual} << 8;
            soNext = 1'b0; // First bit is fault byte MSB, always zero here
        end
        else if (csLow && sclkFall)
        begin
            txNext = {txReg[14:0], 1'b0};
            soNext = txReg[14]; // Next bit right after the falling edge
        end
    end

    // Transmit registers; serial out is registered so it cannot glitch mid-bit
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            txReg <= 16'h0000;
            soReg <= 1'b0;
            oeReg <= 1'b0;
        end
        else
        begin
            txReg <= txNext;
            soReg <= soNext;
            oeReg <= oeNext;
        end
    end

    // Command side: a complete frame is held back until the switching delay runs out
    always_comb
    begin
        cmdNext    = cmdReg;
        pendNext   = pendReg;
        dlyNext    = dlyReg;
        dlyRunNext = dlyRunReg;
        if (csRise)
        begin
            // Only complete 8 or 16 bit frames are accepted; a longer frame is rejected
            if (bitCntReg == 5'h08 || bitCntReg == 5'h10)
            begin
                pendNext   = rxReg[CHANNELS-1:0];
                dlyRunNext = 1'b1;
                dlyNext    = 8'(SWDLY_CYC - 1);
            end
        end
        else if (dlyRunReg)
        begin
            if (dlyReg == 8'h00)
            begin
                dlyRunNext = 1'b0;
                if (!modeHi)
                    cmdNext = pendReg; // Under override the pending frame is dropped; cmdReg keeps its old state
            end
            else
                dlyNext = dlyReg - 8'h01;
        end
    end

    // Command registers; a frame cut short never reaches the gates
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cmdReg    <= '0;
            pendReg   <= '0;
            dlyReg    <= 8'h00;
            dlyRunReg <= 1'b0;
        end
        else
        begin
            cmdReg    <= cmdNext;
            pendReg   <= pendNext;
            dlyReg    <= dlyNext;
            dlyRunReg <= dlyRunNext;
        end
    end

    assign spiSo   = soReg;
    assign spiSoOe = oeReg;

    // Per-channel protection timers; the override gates the serial command off
    for (genvar ch = 0; ch < CHANNELS; ch++)
    begin : g_ch
        sws_channel #(
            .RETRY_CYC   (RETRY_CYC),
            .REFRESH_CYC (REFRESH_CYC),
            .OFFSENS_CYC (OFFSENS_CYC),
            .ONSENS_CYC  (ONSENS_CYC)
        ) u_ch (
            .mclk       (mclk),
            .reset_n    (reset_n),
            .cmdOn      (cmdReg[ch] & ~modeHi),
            .shortSense (shortSense[ch]),
            .openSense  (openSense[ch]),
            .gateOn     (gateOn[ch]),
            .faultQual  (faultQual[ch])
        );
    end
endmodule

// ### rtl/sws_defs.svh
// Timing constants and frame layout for the switch serial port and fault timing
`ifndef SWS_DEFS_SVH
`define SWS_DEFS_SVH
`define SWS_CLK_MHZ           25
`define SWS_RETRY_MIN_US      25
`define SWS_RETRY_MAX_US      100
`define SWS_RETRY_US          50
`define SWS_REFRESH_MIN_US    3000
`define SWS_REFRESH_NOM_US    4500
`define SWS_REFRESH_MAX_US    6000
`define SWS_OFF_SENSE_US      100
`define SWS_ON_SENSE_US       12000
`define SWS_SWITCH_DLY_US     2
`define SWS_SWITCH_DLY_MIN_US 1
`define SWS_SWITCH_DLY_MAX_US 10
`define SWS_SO_EN_NS          110
`define SWS_SO_VALID_NS       80
`define SWS_CMD_CH_BITS       6
`define SWS_FRAME_SHORT       8
`define SWS_FRAME_LONG        16
`define SWS_CNT_W             20
`endif

// ### rtl/sws_pkg.sv
// Types used by the switch channel timers
package sws_pkg;
    typedef enum logic [1:0] {SWS_CH_OFF, SWS_CH_ON, SWS_CH_RETRY, SWS_CH_REFRESH} sws_ch_state_t;
endpackage

// ### rtl/sws_channel.sv
// One output channel: short retry and refresh cycle, open-load qualification
`timescale 1ns/1ps
`include "sws_defs.svh"
module sws_channel #(
    parameter int RETRY_CYC   = `SWS_RETRY_US * `SWS_CLK_MHZ,
    parameter int REFRESH_CYC = `SWS_REFRESH_NOM_US * `SWS_CLK_MHZ,
    parameter int OFFSENS_CYC = `SWS_OFF_SENSE_US * `SWS_CLK_MHZ,
    parameter int ONSENS_CYC  = `SWS_ON_SENSE_US * `SWS_CLK_MHZ
) (
    input  wire logic mclk,
    input  wire logic reset_n,
    input  wire logic cmdOn,
    input  wire logic shortSense,
    input  wire logic openSense,
    output logic      gateOn,
    output logic      faultQual
);
    sws_pkg::sws_ch_state_t stateReg, stateNext;
    logic [`SWS_CNT_W-1:0] tmrReg, tmrNext;
    logic [`SWS_CNT_W-1:0] senseReg, senseNext;
    logic                  cmdReg;
    logic                  gateReg, gateNext;
    logic                  faultReg, faultNext;

    // Short retry sequencer: on, then disabled refresh wait, then retry window in limit
    always_comb
    begin
        stateNext = stateReg;
        tmrNext   = tmrReg;
        gateNext  = 1'b0;
        case (stateReg)
            sws_pkg::SWS_CH_OFF:
            begin
                if (cmdOn)
                    stateNext = sws_pkg::SWS_CH_ON;
            end
            sws_pkg::SWS_CH_ON:
            begin
                gateNext = 1'b1;
                if (!cmdOn)
                    stateNext = sws_pkg::SWS_CH_OFF;
                else if (shortSense)
                begin
                    stateNext = sws_pkg::SWS_CH_REFRESH;
                    tmrNext   = `SWS_CNT_W'(REFRESH_CYC - 1);
                    gateNext  = 1'b0;
                end
            end
            sws_pkg::SWS_CH_RETRY:
            begin
                gateNext = 1'b1; // Output re-enabled in current limit
                if (!cmdOn)
                    stateNext = sws_pkg::SWS_CH_OFF;
                else if (tmrReg == '0)
                begin
                    if (shortSense)
                    begin
                        stateNext = sws_pkg::SWS_CH_REFRESH;
                        tmrNext   = `SWS_CNT_W'(REFRESH_CYC - 1);
                        gateNext  = 1'b0;
                    end
                    else
                        stateNext = sws_pkg::SWS_CH_ON;
                end
                else
                    tmrNext = tmrReg - 1'b1;
            end
            sws_pkg::SWS_CH_REFRESH:
            begin
                if (!cmdOn)
                    stateNext = sws_pkg::SWS_CH_OFF;
                else if (tmrReg == '0)
                begin
                    stateNext = sws_pkg::SWS_CH_RETRY;
                    tmrNext   = `SWS_CNT_W'(RETRY_CYC - 1);
                    gateNext  = 1'b1;
                end
                else
                    tmrNext = tmrReg - 1'b1;
            end
            default:
                stateNext = sws_pkg::SWS_CH_OFF;
        endcase
    end

    // Open load must persist for the sense time of the commanded state; a change restarts it
    always_comb
    begin
        senseNext = '0;
        faultNext = 1'b0;
        if (shortSense && cmdOn)
            faultNext = 1'b1;
        else if (openSense && cmdReg == cmdOn)
        begin
            senseNext = senseReg;
            if (cmdOn && senseReg >= `SWS_CNT_W'(ONSENS_CYC - 1))
                faultNext = 1'b1;
            else if (!cmdOn && senseReg >= `SWS_CNT_W'(OFFSENS_CYC - 1))
                faultNext = 1'b1;
            else
                senseNext = senseReg + 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            stateReg <= sws_pkg::SWS_CH_OFF;
            tmrReg   <= '0;
            senseReg <= '0;
            cmdReg   <= 1'b0;
            gateReg  <= 1'b0;
            faultReg <= 1'b0;
        end
        else
        begin
            stateReg <= stateNext;
            tmrReg   <= tmrNext;
            senseReg <= senseNext;
            cmdReg   <= cmdOn;
            gateReg  <= gateNext;
            faultReg <= faultNext;
        end
    end

    assign gateOn    = gateReg;
    assign faultQual = faultReg;
endmodule

// ### testbench/sws_top_sva.sv
// Port checker for the switch serial port and fault timing
`timescale 1ns/1ps
module sws_top_sva #(
    parameter int CHANNELS = 6
) (
    input wire logic                mclk,
    input wire logic                reset_n,
    input wire logic                spiCs_n,
    input wire logic                spiSclk,
    input wire logic                spiSi,
    input wire logic                spiSo,
    input wire logic                spiSoOe,
    input wire logic                modeOverride,
    input wire logic [CHANNELS-1:0] shortSense,
    input wire logic [CHANNELS-1:0] openSense,
    input wire logic [CHANNELS-1:0] gateOn
);
    // One domain, so one clock and one disable for every property
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);

    reset_quiet_a:
        assert property ($rose(reset_n) |-> gateOn == '0 && !spiSoOe)
        else $error("outputs active just after reset");
    oe_on_a:
        assert property ($fell(spiCs_n) && !modeOverride |=> (!spiCs_n)[*4] ##1 spiSoOe)
        else $error("serial out not enabled after select");
    oe_release_a:
        assert property ($rose(spiCs_n) |-> ##[2:6] !spiSoOe)
        else $error("serial out not released after deselect");
    oe_idle_a:
        assert property (spiCs_n [*6] |-> !spiSoOe)
        else $error("serial out driven while deselected");
    mode_hiz_a:
        assert property (modeOverride [*5] |-> !spiSoOe)
        else $error("serial out driven under override");
    gate_hold_a:
        assert property ($rose(spiCs_n) && shortSense == '0 |=> $stable(gateOn) [*5])
        else $error("gates switched too soon after deselect");
    refresh_wait_a:
        assert property ($fell(gateOn[0]) && shortSense[0]
            |=> !gateOn[0] [*8] ##[28:36] gateOn[0])
        else $error("refresh wait length wrong");
    retry_len_a:
        assert property ($rose(gateOn[0]) && shortSense[0]
            |=> gateOn[0] [*6] ##[1:4] !gateOn[0])
        else $error("retry window length wrong");
endmodule

bind sws_top sws_top_sva #(.CHANNELS(CHANNELS)) chk (.mclk(mclk), .reset_n(reset_n),
    .spiCs_n(spiCs_n), .spiSclk(spiSclk), .spiSi(spiSi), .spiSo(spiSo),
    .spiSoOe(spiSoOe), .modeOverride(modeOverride), .shortSense(shortSense),
    .openSense(openSense), .gateOn(gateOn));

// ### testbench/sws_spi_master.sv
// Serial bus master model that frames commands into the switch
`timescale 1ns/1ps
module sws_spi_master (
    input  wire logic mclk,
    input  wire logic so,
    input  wire logic soOe,
    output logic      csN,
    output logic      sclk,
    output logic      si
);
    logic soLine;

    // A released serial out floats to its pull-up level
    assign soLine = soOe ? so : 1'b1;

    // Idle bus: deselected, clock parked low, data at its pull-down level
    initial
    begin
        csN = 1'b1;
        sclk = 1'b0;
        si = 1'b0;
    end

    // SO is read just before each falling edge, since the port answers late
    task automatic xfer(input int n, input logic [15:0] tx, output logic [15:0] rx,
                        output int oeCnt);
        rx = 16'h0000;
        oeCnt = 0;
        @(negedge mclk);
        csN = 1'b0;
        #320;
        for (int i = n - 1; i >= 0; i--)
        begin
            si = tx[i];
            #160;
            sclk = 1'b1;
            #160;
            rx = {rx[14:0], soLine};
            oeCnt += int'(soOe === 1'b1);
            sclk = 1'b0;
        end
        #160;
        csN = 1'b1;
        si = 1'b0;
        #1000;
    endtask
endmodule

// ### testbench/sws_top_bench.sv
// Self-checking bench for the switch serial port and fault timing
`timescale 1ns/1ps
module sws_top_bench;
    localparam int RET = 8;
    localparam int REF = 40;
    localparam int OFFS = 10;
    localparam int ONS = 60;
    logic        mclk;
    logic        reset_n;
    logic        spiCs_n;
    logic        spiSclk;
    logic        spiSi;
    logic        spiSo;
    logic        spiSoOe;
    logic        modeOverride;
    logic [5:0]  shortSense;
    logic [5:0]  openSense;
    logic [5:0]  gateOn;
    logic [15:0] rx;
    int          oeCnt;
    int          miscompares;
    int          cmp_count;

    sws_top #(.RETRY_CYC(RET), .REFRESH_CYC(REF), .OFFSENS_CYC(OFFS), .ONSENS_CYC(ONS),
        .SWDLY_CYC(4)) dut (.mclk(mclk), .reset_n(reset_n), .spiCs_n(spiCs_n),
        .spiSclk(spiSclk), .spiSi(spiSi), .spiSo(spiSo), .spiSoOe(spiSoOe),
        .modeOverride(modeOverride), .shortSense(shortSense), .openSense(openSense),
        .gateOn(gateOn));
    sws_spi_master bfm (.mclk(mclk), .so(spiSo), .soOe(spiSoOe), .csN(spiCs_n),
        .sclk(spiSclk), .si(spiSi));

    // 25 MHz system clock
    always #20 mclk = ~mclk;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("Counts: %0d mismatches, %0d comparisons", miscompares, cmp_count);
        if (miscompares == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Bounded wait on channel zero's gate; n returns the cycles spent
    task automatic until0(input logic v, output int n);
        for (n = 0; n < 300 && gateOn[0] !== v; n++)
            @(negedge mclk);
    endtask

    task automatic t_frames();
        bfm.xfer(8, 16'h002A, rx, oeCnt);
        chk(rx, 16'h0000);
        chk(16'(oeCnt), 16'h0008);
        repeat (40) @(negedge mclk);
        chk({10'h000, gateOn}, 16'h002A);
        bfm.xfer(16, 16'hFF15, rx, oeCnt);
        repeat (40) @(negedge mclk);
        chk({10'h000, gateOn}, 16'h0015);
        bfm.xfer(12, 16'h003F, rx, oeCnt);
        repeat (40) @(negedge mclk);
        chk({10'h000, gateOn}, 16'h0015);
    endtask

    task automatic t_open();
        openSense = 6'h02;
        repeat (OFFS + 5) @(negedge mclk);
        bfm.xfer(8, 16'h0017, rx, oeCnt);
        chk(rx, 16'h0002);
        repeat (ONS + 10) @(negedge mclk);
        bfm.xfer(16, 16'h0015, rx, oeCnt);
        chk(rx, 16'h0200);
        openSense = 6'h00;
    endtask

    task automatic t_short();
        int n;
        shortSense = 6'h01;
        until0(1'b0, n);
        chk({10'h000, gateOn}, 16'h0014);
        bfm.xfer(8, 16'h0015, rx, oeCnt);
        chk(rx, 16'h0001);
        until0(1'b1, n);
        until0(1'b0, n);
        until0(1'b1, n);
        chk({15'h0000, n inside {[REF-1:REF+1]}}, 16'h0001);
        until0(1'b0, n);
        chk({15'h0000, n inside {[RET-1:RET+1]}}, 16'h0001);
        shortSense = 6'h00;
        repeat (REF + RET + 10) @(negedge mclk);
        chk({10'h000, gateOn}, 16'h0015);
    endtask

    task automatic t_mode();
        modeOverride = 1'b1;
        repeat (5) @(negedge mclk);
        bfm.xfer(8, 16'h0000, rx, oeCnt);
        chk(16'(oeCnt), 16'h0000);
        chk(rx, 16'h00FF);
        repeat (40) @(negedge mclk);
        chk({10'h000, gateOn}, 16'h0000);
        modeOverride = 1'b0;
        repeat (10) @(negedge mclk);
        chk({10'h000, gateOn}, 16'h0015);
    endtask

    // Main sequence: reset for two cycles, then the scenarios in turn
    initial
    begin
        mclk = 1'b0;
        reset_n = 1'b0;
        modeOverride = 1'b0;
        shortSense = 6'h00;
        openSense = 6'h00;
        miscompares = 0;
        cmp_count = 0;
        repeat (2) @(negedge mclk);
        reset_n = 1'b1;
        chk({10'h000, gateOn}, 16'h0000);
        t_frames();
        t_open();
        t_short();
        t_mode();
        close_out();
    end

    // Watchdog: the scenarios need well under a millisecond
    initial
    begin
        #2000000;
        miscompares++;
        close_out();
    end
endmodule
